//--- apm_pkg.sv
// constants and types of the auxiliary pin function selector
package apm_pkg;

    // ********************************************************
    // pin count and configuration field layout
    // ********************************************************
    localparam int NPIN = 11;  // auxiliary pins
    localparam int FW   = 4;   // function code bits per pin
    localparam int DW   = 2;   // drive strength bits per pin

    // function menu, one code per pin
    typedef enum logic [3:0] {
        F_RS485_DRIVE_ENABLE  = 4'h0,  // rs485 drive enable
        F_PWR    = 4'h1,  // power switch, low = powered
        F_TX_ACTIVITY_LED_N  = 4'h2,  // transmit activity led
        F_RX_ACTIVITY_LED_N  = 4'h3,  // receive activity led
        F_ANYLED = 4'h4,  // either activity led
        F_SLEEP  = 4'h5,  // suspend indicator
        F_CLKOUT_30M  = 4'h6,  // clock output, top rate
        F_CLKOUT_15M  = 4'h7,  // clock output, half rate
        F_CLK7M5 = 4'h8,  // clock output, quarter rate
        F_UNUSED = 4'h9,  // pulled-up input
        F_DRV1   = 4'ha,  // constant high
        F_DRV0   = 4'hb,  // constant low
        F_SWIO   = 4'hc   // software i/o
    } apm_func_t;

    // pins still free for software i/o while the uart runs
    localparam logic [10:0] SWIO_UART_MASK = 11'h360;

    // ********************************************************
    // register map (byte addresses)
    // ********************************************************
    localparam logic [7:0] REG_DIR  = 8'h00;  // 1 = drive
    localparam logic [7:0] REG_OUT  = 8'h04;  // output level
    localparam logic [7:0] REG_IN   = 8'h08;  // pin levels
    localparam logic [7:0] REG_STAT = 8'h0c;  // status
    localparam int ST_LOADED = 0;  // settings latched
    localparam int ST_UART   = 1;  // serial port active
    localparam int ST_SUSP   = 2;  // bus suspended
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************
    // timing
    // ********************************************************
    localparam longint CLK_HZ    = 100_000_000;
    localparam longint CLKOUT_HZ = 30_000_000;
    localparam int     ACC_W     = 16;
    localparam logic [15:0] ACC_STEP =
        16'((CLKOUT_HZ << ACC_W) / CLK_HZ);
    localparam int LED_PULSE_NS = 10_000;  // least led pulse
    localparam int CLK_NS       = 10;
    localparam int LED_CYC =
        (LED_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LED_W = 10;

endpackage

//--- apm_mux.sv
// auxiliary pin function selector with axi4-lite registers
`timescale 1ns/10ps

module apm_mux
    import apm_pkg::*;
#(
    parameter int ADDR_W  = 8,        // axi address width
    parameter int LED_LEN = LED_CYC   // led pulse in cycles
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // settings from the configuration memory loader
    input  wire logic                cfg_load,
    input  wire logic [NPIN*FW-1:0]  cfg_func,
    input  wire logic [NPIN-1:0]     cfg_inv,
    input  wire logic [NPIN*DW-1:0]  cfg_drive,
    // device activity
    input  wire logic                tx_shifting,
    input  wire logic                tx_strobe,
    input  wire logic                rx_strobe,
    input  wire logic                suspend,
    input  wire logic                uart_active,
    // pads
    input  wire logic [NPIN-1:0]     pin_in,
    output logic [NPIN-1:0]          pin_out,
    output logic [NPIN-1:0]          pin_oe_n,
    output logic [NPIN-1:0]          pin_pullup,
    output logic [NPIN*DW-1:0]       pin_drive
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic               loaded;  // settings latched
        logic [NPIN*FW-1:0] func;    // function codes
        logic [NPIN-1:0]    inv;     // output inversion
        logic [NPIN*DW-1:0] drv;     // drive strength
        logic [NPIN-1:0]    dir;     // software direction
        logic [NPIN-1:0]    outv;    // software level
        logic [NPIN-1:0]    s1;      // sync stage 1
        logic [NPIN-1:0]    s2;      // sync stage 2
        logic [NPIN-1:0]    s3;      // sync stage 3
        logic [NPIN-1:0]    ins;     // settled pin levels
        logic [LED_W-1:0]   txcnt;   // tx led stretch
        logic [LED_W-1:0]   rxcnt;   // rx led stretch
        logic [ACC_W-1:0]   acc;     // phase accumulator
        logic               c15;     // half-rate clock
        logic               c7;      // quarter-rate clock
        logic [NPIN-1:0]    pout;    // pad level
        logic [NPIN-1:0]    poe_n;   // pad enable, low on
        logic [NPIN-1:0]    ppu;     // pad pull-up
        logic               aw_ok;   // address held
        logic [ADDR_W-1:0]  awa;     // held address
        logic               w_ok;    // data held
        logic [31:0]        wd;      // held data
        logic [3:0]         ws;      // held strobes
        logic               bv;      // write answer
        logic [1:0]         br;      // write status
        logic               rv;      // read answer
        logic [31:0]        rd;      // read data
        logic [1:0]         rr;      // read status
    } apm_state_t;

    apm_state_t r_reg;   // registered state
    apm_state_t r_next;  // next state

    // ********************************************************
    // outputs
    // ********************************************************
    assign awready    = !r_reg.aw_ok && !r_reg.bv;
    assign wready     = !r_reg.w_ok && !r_reg.bv;
    assign bvalid     = r_reg.bv;
    assign bresp      = r_reg.br;
    assign arready    = !r_reg.rv;
    assign rvalid     = r_reg.rv;
    assign rdata      = r_reg.rd;
    assign rresp      = r_reg.rr;
    assign pin_out    = r_reg.pout;
    assign pin_oe_n   = r_reg.poe_n;
    assign pin_pullup = r_reg.ppu;
    assign pin_drive  = r_reg.drv;

    // ********************************************************
    // next-state logic
    // ********************************************************
    // everything lives in one struct; this process fills the
    // copy, the clocked process below only stores it
    always_comb begin
        logic [3:0]  f;       // function of one pin
        logic        v;       // unregistered level
        logic        oen;     // unregistered enable
        logic        pu;      // unregistered pull-up
        logic [10:0] m;       // write byte mask
        logic [NPIN-1:0] ch;  // sync stages disagree
        logic        dowr;    // write completes now
        f    = 4'h0;
        v    = 1'b0;
        oen  = 1'b1;
        pu   = 1'b1;
        m    = {{3{r_reg.ws[1]}}, {8{r_reg.ws[0]}}};
        ch   = '0;
        dowr = 1'b0;
        r_next = r_reg;

        // settings taken once per reset, later loads ignored
        if (cfg_load && !r_reg.loaded) begin
            r_next.loaded = 1'b1;
            r_next.func   = cfg_func;
            r_next.inv    = cfg_inv;
            r_next.drv    = cfg_drive;
        end

        // pads: three stages, a change counts once the
        // second and third agree
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        ch = r_reg.s2 ^ r_reg.s3;
        r_next.ins = (r_reg.s2 & ~ch) | (r_reg.ins & ch);

        // led stretch: a new strobe restarts the pulse so a
        // busy link shows a steadily lit led
        if (tx_strobe) begin
            r_next.txcnt = LED_W'(LED_LEN);
        end else if (r_reg.txcnt != '0) begin
            r_next.txcnt = r_reg.txcnt - 1'b1;
        end
        if (rx_strobe) begin
            r_next.rxcnt = LED_W'(LED_LEN);
        end else if (r_reg.rxcnt != '0) begin
            r_next.rxcnt = r_reg.rxcnt - 1'b1;
        end

        // clock outputs: the top rate is not a whole divisor
        // of the system clock, so an accumulator gives the
        // right mean rate with one cycle of edge jitter
        r_next.acc = r_reg.acc + ACC_STEP;
        if (!r_reg.acc[ACC_W-1] && r_next.acc[ACC_W-1]) begin
            r_next.c15 = !r_reg.c15;
            if (!r_reg.c15) begin
                r_next.c7 = !r_reg.c7;
            end
        end

        // per-pin function selection
        for (int i = 0; i < NPIN; i++) begin
            f   = r_reg.func[i*FW +: FW];
            v   = 1'b1;
            oen = 1'b0;
            pu  = 1'b0;
            case (f)
                F_RS485_DRIVE_ENABLE: begin
                    v = tx_shifting;
                end
                F_PWR: begin
                    v = suspend;
                end
                F_TX_ACTIVITY_LED_N: begin
                    v = (r_reg.txcnt == '0);
                end
                F_RX_ACTIVITY_LED_N: begin
                    v = (r_reg.rxcnt == '0);
                end
                F_ANYLED: begin
                    v = (r_reg.txcnt == '0) &&
                        (r_reg.rxcnt == '0);
                end
                F_SLEEP: begin
                    v = !suspend;
                end
                F_CLKOUT_30M: begin
                    v = r_reg.acc[ACC_W-1];
                end
                F_CLKOUT_15M: begin
                    v = r_reg.c15;
                end
                F_CLK7M5: begin
                    v = r_reg.c7;
                end
                F_DRV1: begin
                    v = 1'b1;
                end
                F_DRV0: begin
                    v = 1'b0;
                end
                F_SWIO: begin
                    // uart owns all but four pins while active
                    if (uart_active &&
                        !SWIO_UART_MASK[i]) begin
                        oen = 1'b1;
                        pu  = 1'b1;
                    end else begin
                        oen = !r_reg.dir[i];
                        v   = r_reg.outv[i];
                    end
                end
                default: begin
                    // unused and undefined codes float high
                    oen = 1'b1;
                    pu  = 1'b1;
                end
            endcase
            if (!r_reg.loaded) begin
                oen = 1'b1;
                pu  = 1'b1;
            end
            r_next.pout[i]  = v ^ r_reg.inv[i];
            r_next.poe_n[i] = oen;
            r_next.ppu[i]   = pu;
        end

        // axi write: address and data taken in either order
        if (awvalid && awready) begin
            r_next.aw_ok = 1'b1;
            r_next.awa   = awaddr;
        end
        if (wvalid && wready) begin
            r_next.w_ok = 1'b1;
            r_next.wd   = wdata;
            r_next.ws   = wstrb;
        end
        dowr = r_reg.aw_ok && r_reg.w_ok;
        if (dowr) begin
            r_next.aw_ok = 1'b0;
            r_next.w_ok  = 1'b0;
            r_next.bv    = 1'b1;
            r_next.br    = RESP_OKAY;
            case (r_reg.awa[7:0])
                REG_DIR: begin
                    r_next.dir = (r_reg.dir & ~m) |
                                 (r_reg.wd[10:0] & m);
                end
                REG_OUT: begin
                    r_next.outv = (r_reg.outv & ~m) |
                                  (r_reg.wd[10:0] & m);
                end
                REG_IN, REG_STAT: begin
                    // read-only, write ignored
                    r_next.br = RESP_OKAY;
                end
                default: begin
                    r_next.br = RESP_SLVERR;
                end
            endcase
        end
        if (r_reg.bv && bready) begin
            r_next.bv = 1'b0;
        end

        // axi read: one outstanding, data registered
        if (r_reg.rv && rready) begin
            r_next.rv = 1'b0;
        end
        if (arvalid && arready) begin
            r_next.rv = 1'b1;
            r_next.rr = RESP_OKAY;
            r_next.rd = '0;
            case (araddr[7:0])
                REG_DIR: begin
                    r_next.rd[10:0] = r_reg.dir;
                end
                REG_OUT: begin
                    r_next.rd[10:0] = r_reg.outv;
                end
                REG_IN: begin
                    r_next.rd[10:0] = r_reg.ins;
                end
                REG_STAT: begin
                    r_next.rd[ST_LOADED] = r_reg.loaded;
                    r_next.rd[ST_UART]   = uart_active;
                    r_next.rd[ST_SUSP]   = suspend;
                end
                default: begin
                    r_next.rr = RESP_SLVERR;
                end
            endcase
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    // reset leaves every pad as a pulled-up input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg       <= '0;
            r_reg.poe_n <= '1;
            r_reg.ppu   <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ********************************************************
    // assertions; the per-function ones each watch one pin of their function
    // ********************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [3:0] f0;  // function of pin 0
    assign f0 = r_reg.func[3:0];

    pull_before_load_a: assert property (
        !r_reg.loaded |=> (&pin_oe_n) && (&pin_pullup))
        else $error("pins driven before settings latched");

    load_once_a: assert property (
        r_reg.loaded |=> $stable(r_reg.func) && r_reg.loaded)
        else $error("settings changed after latch");

    rs485_drive_enable_follow_a: assert property (
        r_reg.loaded && f0 == F_RS485_DRIVE_ENABLE && !r_reg.inv[0]
        |=> pin_out[0] == $past(tx_shifting) && !pin_oe_n[0])
        else $error("drive enable not following shifter");

    power_suspend_a: assert property (
        r_reg.loaded && r_reg.func[7:4] == F_PWR && !r_reg.inv[1]
        |=> pin_out[1] == $past(suspend))
        else $error("power switch level wrong");

    tx_led_pulse_a: assert property (
        r_reg.loaded && r_reg.func[11:8] == F_TX_ACTIVITY_LED_N && !r_reg.inv[2]
        && tx_strobe && $stable(r_reg.func)
        |-> ##2 !pin_out[2] [*3])
        else $error("tx led pulse missing");

    unused_pullup_a: assert property (
        r_reg.loaded && r_reg.func[15:12] == F_UNUSED
        |=> pin_oe_n[3] && pin_pullup[3])
        else $error("unused pin not pulled-up input");

    drive_const_a: assert property (
        r_reg.loaded && r_reg.func[23:20] == F_DRV0
        |=> !pin_oe_n[5] && pin_out[5] == r_reg.inv[5])
        else $error("constant low not driven");

    swio_uart_lock_a: assert property (
        r_reg.loaded && r_reg.func[43:40] == F_SWIO && uart_active
        |=> pin_oe_n[10] && pin_pullup[10])
        else $error("pin 10 software i/o during uart");

    write_answer_a: assert property (
        awvalid && awready && wvalid && wready
        |-> ##2 bvalid)
        else $error("write answer missing");

    read_answer_a: assert property (
        arvalid && arready |=> rvalid ##0 rresp != 2'h1)
        else $error("read answer missing");

    load_seen_c: cover property (
        !r_reg.loaded ##1 r_reg.loaded);
    led_pulse_c: cover property (
        r_reg.func[11:8] == F_TX_ACTIVITY_LED_N && tx_strobe ##2 !pin_out[2]);
    swio_drive_c: cover property (
        r_reg.func[23:20] == F_SWIO && bvalid && bready
        ##1 !pin_oe_n[5]);

endmodule

//--- apm_fix_note_unused.sv
// spare file of the block: it holds no logic

//--- apm_pad_model.sv
// far side of the auxiliary pins: pads, pull-ups, outside drivers
`timescale 1ns/10ps

module apm_pad_model
    import apm_pkg::*;
(
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe_n,
    input  wire logic [NPIN-1:0] pin_pullup,
    input  wire logic [NPIN-1:0] ext_en,
    input  wire logic [NPIN-1:0] ext_level,
    input  wire logic            aclk,
    output logic      [NPIN-1:0] pin_in
);
    // ********************************************************
    // wire resolution
    // ********************************************************
    logic [NPIN-1:0] float_lvl = 11'h000;  // level of a floating line

    // a floating line flips each cycle so no stale level can pass
    always @(posedge aclk) begin
        float_lvl <= ~float_lvl;
    end

    // device driver wins, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_lvl[i];
            end
        end
    end
endmodule

//--- testbench.sv
// self-checking bench for the auxiliary pin function selector
`timescale 1ns/10ps

module testbench
    import apm_pkg::*;
;
    // ********************************************************
    // signals
    // ********************************************************
    localparam int LLEN = 4;  // short led pulse keeps the run brief
    logic               aclk        = 1'b0;
    logic               aresetn     = 1'b0;
    logic [7:0]         awaddr      = 8'h00;
    logic [7:0]         araddr      = 8'h00;
    logic [31:0]        wdata       = 32'h0;
    logic [3:0]         wstrb       = 4'hf;
    logic               awvalid     = 1'b0;
    logic               wvalid      = 1'b0;
    logic               bready      = 1'b0;
    logic               arvalid     = 1'b0;
    logic               rready      = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp;
    logic [31:0]        rdata;
    logic               cfg_load    = 1'b0;
    logic [NPIN*FW-1:0] cfg_func    = 44'h0;
    logic [NPIN-1:0]    cfg_inv     = 11'h000;
    logic [NPIN*DW-1:0] cfg_drive   = 22'h0;
    logic               tx_shifting = 1'b0;
    logic               tx_strobe   = 1'b0;
    logic               rx_strobe   = 1'b0;
    logic               suspend     = 1'b0;
    logic               uart_active = 1'b0;
    logic [NPIN-1:0]    ext_en      = 11'h000;
    logic [NPIN-1:0]    ext_level   = 11'h000;
    logic [NPIN-1:0]    pin_in, pin_out, pin_oe_n, pin_pullup;
    logic [NPIN*DW-1:0] pin_drive;
    int                 miscompares = 0;
    int                 comparisons = 0;

    apm_mux #(.ADDR_W(8), .LED_LEN(LLEN)) dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .cfg_load, .cfg_func,
        .cfg_inv, .cfg_drive, .tx_shifting, .tx_strobe, .rx_strobe,
        .suspend, .uart_active, .pin_in, .pin_out, .pin_oe_n, .pin_pullup,
        .pin_drive
    );

    apm_pad_model pad_u (
        .pin_out, .pin_oe_n, .pin_pullup, .ext_en, .ext_level, .aclk,
        .pin_in
    );

    // 100 mhz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // ********************************************************
    // tasks
    // ********************************************************
    task automatic end_of_test;
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // drives change right after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // sample mid-cycle, where the next edge's values are settled
    task automatic look;
        @(negedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic       ah, wh, bh;
        logic [1:0] r;
        int         n;
        bh = 1'b0;
        r = ~er;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at the edge that takes it
        while (!bh && n < 100) begin
            look;
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic        ah, rh;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        rh = 1'b0;
        d = ~ed;
        r = ~er;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rh && n < 100) begin
            look;
            ah = arvalid && arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        check("rdata", ed, d);
        check("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        tick(12);
        aresetn <= 1'b1;
    endtask

    task automatic load_cfg(input logic [43:0] f, input logic [10:0] inv);
        @(posedge aclk);
        cfg_func <= f;
        cfg_inv <= inv;
        cfg_load <= 1'b1;
        @(posedge aclk);
        cfg_load <= 1'b0;
        tick(3);
    endtask

    // one strobe, then the chosen led pins of 2..4 low for a while, then all three idle high
    task automatic led_pulse(input logic tx, input logic rx,
                             input logic [10:0] low);
        @(posedge aclk);
        tx_strobe <= tx;
        rx_strobe <= rx;
        @(posedge aclk);
        tx_strobe <= 1'b0;
        rx_strobe <= 1'b0;
        tick(3);
        look;
        check("led pulse", 32'(~low & 11'h01c),
              32'(pin_out & 11'h01c));
        tick(LLEN + 2);
        look;
        check("led idle", 32'h1c, 32'(pin_out & 11'h01c));
    endtask

    // rising edges of pins 0..2 over 1000 cycles: 300, 150, 75
    task automatic count_clk;
        int         c [3];
        logic [2:0] prev;
        c = '{0, 0, 0};
        look;
        prev = pin_out[2:0];
        repeat (1000) begin
            look;
            for (int k = 0; k < 3; k++) if (pin_out[k] && !prev[k]) c[k]++;
            prev = pin_out[2:0];
        end
        for (int k = 0; k < 3; k++) begin
            check("clkout rate", 32'h1, 32'(c[k] >= 300 / (1 << k) - 2 &&
                  c[k] <= 300 / (1 << k) + 2));
        end
    endtask

    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        do_reset;
        look;
        check("oe before load", 32'h7ff, 32'(pin_oe_n));
        check("pullup before load", 32'h7ff, 32'(pin_pullup));
        axi_rd(REG_STAT, 32'h0, RESP_OKAY);
        load_cfg({F_SWIO, F_SWIO, F_SWIO, F_SLEEP, F_SWIO, F_SWIO, F_ANYLED,
                  F_RX_ACTIVITY_LED_N, F_TX_ACTIVITY_LED_N, F_PWR, F_RS485_DRIVE_ENABLE}, 11'h000);
        look;
        check("fixed pins oe", 32'h0, 32'(pin_oe_n & 11'h09f));
        check("idle levels", 32'h09c, 32'(pin_out & 11'h09f));
        load_cfg(44'h0, 11'h7ff);
        look;
        check("reload ignored", 32'h09c, 32'(pin_out & 11'h09f));
        tick(1);
        tx_shifting <= 1'b1;
        tick(2);
        look;
        check("drive enable on", 32'h1, 32'(pin_out[0]));
        tick(1);
        tx_shifting <= 1'b0;
        tick(2);
        look;
        check("drive enable off", 32'h0, 32'(pin_out[0]));
        tick(1);
        suspend <= 1'b1;
        tick(2);
        look;
        check("suspend levels", 32'h002, 32'(pin_out & 11'h082));
        axi_rd(REG_STAT, 32'h5, RESP_OKAY);
        suspend <= 1'b0;
        tick(2);
        look;
        check("resume levels", 32'h080, 32'(pin_out & 11'h082));
        led_pulse(1'b1, 1'b0, 11'h014);
        led_pulse(1'b0, 1'b1, 11'h018);
        axi_wr(REG_DIR, 32'h760, RESP_OKAY);
        axi_wr(REG_OUT, 32'h520, RESP_OKAY);
        // upper strobe only: the low byte of the level must survive
        wstrb <= 4'h2;
        axi_wr(REG_OUT, 32'h5ff, RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(REG_DIR, 32'h760, RESP_OKAY);
        axi_rd(REG_OUT, 32'h520, RESP_OKAY);
        look;
        check("swio drive", 32'h0, 32'(pin_oe_n & 11'h760));
        check("swio levels", 32'h520, 32'(pin_out & 11'h760));
        tick(4);
        axi_rd(REG_IN, 32'h5bc, RESP_OKAY);
        ext_en <= 11'h200;
        ext_level <= 11'h200;
        axi_wr(REG_DIR, 32'h560, RESP_OKAY);
        tick(6);
        axi_rd(REG_IN, 32'h7bc, RESP_OKAY);
        axi_wr(REG_IN, 32'h0, RESP_OKAY);
        axi_rd(REG_IN, 32'h7bc, RESP_OKAY);
        axi_wr(8'h10, 32'h1, RESP_SLVERR);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        uart_active <= 1'b1;
        tick(2);
        look;
        check("uart keeps io", 32'h0, 32'(pin_oe_n & 11'h160));
        check("uart frees pin", 32'h400,
              32'(pin_oe_n & pin_pullup & 11'h400));
        axi_rd(REG_STAT, 32'h3, RESP_OKAY);
        uart_active <= 1'b0;
        ext_en <= 11'h000;
        do_reset;
        cfg_drive <= 22'h1e4c93;
        load_cfg({F_UNUSED, F_UNUSED, F_UNUSED, F_UNUSED, F_DRV1, F_DRV0,
                  F_DRV1, F_UNUSED, F_CLK7M5, F_CLKOUT_15M, F_CLKOUT_30M},
                 11'h040);
        look;
        check("const levels", 32'h010, 32'(pin_out & 11'h070));
        check("const drive", 32'h0, 32'(pin_oe_n & 11'h077));
        check("unused pins", 32'h788,
              32'(pin_oe_n & pin_pullup & 11'h788));
        check("drive strength", 32'(22'h1e4c93), 32'(pin_drive));
        count_clk;
        end_of_test;
    end

    // watchdog: the tests need about 1150 cycles
    initial begin
        #100us;
        miscompares++;
        end_of_test;
    end
endmodule
